// ### card_select_map.svh
// constants for the card channel and file select decoder
`ifndef CARD_SELECT_MAP_SVH
`define CARD_SELECT_MAP_SVH
`define INS_SELECT       8'hA4
`define INS_MANAGE_CHAN  8'h70
`define P1_BY_FILE       8'h00
`define P1_CHILD_DIR     8'h01
`define P1_PARENT_DIR    8'h03
`define P1_BY_APP_ID     8'h04
`define P1_PATH_ROOT     8'h08
`define P1_PATH_CURRENT  8'h09
`define P2_NO_DATA       8'h0C
`define RESP_TEMPLATE    3'b001
`define RESP_NONE        3'b011
`define SESSION_TERM     2'b10
`define SW_OK            16'h9000
`define SW_BAD_P1P2      16'h6A86
`define SW_NO_INS        16'h6D00
`define SW_NO_CHAN       16'h6881
`define SW_TOOLKIT_HI    8'h91
`define SW_TOOLKIT_B     16'h9300
`define SW_CONDITIONS    16'h6985
`define SW_NO_FILE       16'h6A82
`define CHAN_COUNT       4
`define CHAN_OPEN_RESET  4'h1
`endif

// ### card_select_pkg.sv
// types for the card channel and file select decoder
package card_select_pkg;
  typedef enum logic [2:0] {
    METHOD_FILE    = 3'd0,
    METHOD_CHILD   = 3'd1,
    METHOD_PARENT  = 3'd2,
    METHOD_APP_ID  = 3'd3,
    METHOD_PATH_RT = 3'd4,
    METHOD_PATH_CD = 3'd5
  } select_method_e;
  typedef enum logic [1:0] {
    OCC_FIRST = 2'b00,
    OCC_LAST  = 2'b01,
    OCC_NEXT  = 2'b10,
    OCC_PREV  = 2'b11
  } occurrence_e;
  typedef enum logic [1:0] {
    DATA_FILE_NUMBER = 2'd0,
    DATA_DIR_NAME    = 2'd1,
    DATA_PATH        = 2'd2,
    DATA_NONE        = 2'd3
  } data_meaning_e;
endpackage

// ### card_channel_file_select_decoder.sv
// command decoder for channel routing and file selection
`timescale 1ns/10ps
`include "card_select_map.svh"
module card_channel_file_select_decoder
  import card_select_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // command header, one-cycle strobe from the byte receiver
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdCla,
  input  wire logic [7:0]  cmdIns,
  input  wire logic [7:0]  cmdP1,
  input  wire logic [7:0]  cmdP2,
  input  wire logic [7:0]  cmdLc,
  // terminal and file system status
  input  wire logic        cardToolkitSupport,
  input  wire logic        searchFound,
  input  wire logic [1:0]  openChanNum,
  input  wire logic        openChanValid,
  input  wire logic [1:0]  closeChanNum,
  input  wire logic        closeChanValid,
  input  wire logic        toolkitPending,
  input  wire logic [7:0]  toolkitLen,
  // decoded result
  output logic             decValid,
  output logic [1:0]       channelNum,
  output select_method_e   selMethod,
  output data_meaning_e    dataMeaning,
  output logic [1:0]       sessionCtrl,
  output logic             sessionApplies,
  output occurrence_e      occurrence,
  output logic             sendTemplate,
  output logic             selectRoot,
  output logic             prefixMatch,
  output logic [1:0]       searchStage,
  output logic             pointersValid,
  output logic [3:0]       chanOpen,
  output logic [15:0]      statusWord
);

  // combinational decode of one header
  // every decoded field is worked out from the header in the strobe cycle
  // and captured by the result flops at that same edge
  // outside the strobe the header fields carry no meaning and are ignored
  logic            p1Ok;          // P1 is one of the six methods
  logic            p2Ok;          // P2 coding accepted
  logic            isSelect;      // instruction is a file select
  logic            chanOk;        // addressed channel is open
  logic            tryToolkit;    // pending toolkit data may be flagged
  select_method_e  methodNext;    // method from P1
  data_meaning_e   meaningNext;   // meaning of the data field
  logic [15:0]     swNext;        // status word for this header
  logic [1:0]      chanIn;        // channel from the class byte
  logic [3:0]      chanOpen_reg;  // open channel set
  wire logic [3:0] chanOpen_next; // next open flag per channel
  logic            searchRun_reg; // file-id search still walking

  // channel number rides in the two low class bits
  assign chanIn = cmdCla[1:0];

  // open set leaves the block straight from its flops
  assign chanOpen = chanOpen_reg;

  // method, data meaning and legality
  // unknown P1 codes leave the defaults and flag the header as bad
  // the method picks how the data field is read
  always_comb begin
    p1Ok        = 1'b1;
    methodNext  = METHOD_FILE;
    meaningNext = DATA_FILE_NUMBER;
    unique case (cmdP1)
      `P1_BY_FILE: begin
        methodNext  = METHOD_FILE;
        meaningNext = (cmdLc == 8'h00) ? DATA_NONE : DATA_FILE_NUMBER;
      end
      `P1_CHILD_DIR: begin
        methodNext  = METHOD_CHILD;
        meaningNext = DATA_FILE_NUMBER;
      end
      `P1_PARENT_DIR: begin
        methodNext  = METHOD_PARENT;
        meaningNext = DATA_NONE;
      end
      `P1_BY_APP_ID: begin
        methodNext  = METHOD_APP_ID;
        meaningNext = DATA_DIR_NAME;
      end
      `P1_PATH_ROOT: begin
        methodNext  = METHOD_PATH_RT;
        meaningNext = DATA_PATH;
      end
      `P1_PATH_CURRENT: begin
        methodNext  = METHOD_PATH_CD;
        meaningNext = DATA_PATH;
      end
      default: begin
        p1Ok = 1'b0;
      end
    endcase
  end

  // P2 legality
  // b8 must be clear and b5..b3 must ask for a template or for nothing
  // b2 b1 are checked only for the empty P1 zero select: otherwise they only steer an application id search
  always_comb begin
    p2Ok = ~cmdP2[7] &&
           ((cmdP2[4:2] == `RESP_TEMPLATE) || (cmdP2[4:2] == `RESP_NONE));
    // session control only 00 or 10, and only checked for app id
    if (cmdP1 == `P1_BY_APP_ID && cmdP2[5]) begin
      p2Ok = 1'b0;
    end
    // empty data with P1 zero requires exactly no-data coding
    if (cmdP1 == `P1_BY_FILE && cmdLc == 8'h00 && cmdP2 != `P2_NO_DATA) begin
      p2Ok = 1'b0;
    end
  end

  // only the select instruction is implemented here
  // a closed channel is looked up in the open set
  // toolkit status needs both pending data and a toolkit terminal
  assign isSelect   = (cmdIns == `INS_SELECT);
  assign chanOk     = chanOpen_reg[chanIn];
  assign tryToolkit = toolkitPending && cardToolkitSupport;

  // status word choice
  // checks run in a fixed priority, first failure wins
  // 9300 is never produced by this block
  // parent selection and the empty root select never miss
  always_comb begin
    if (!isSelect) begin
      swNext = `SW_NO_INS;
    end else if (!chanOk) begin
      swNext = `SW_NO_CHAN;
    end else if (!p1Ok || !p2Ok) begin
      swNext = `SW_BAD_P1P2;
    end else if (!searchFound && methodNext != METHOD_PARENT &&
                 !(methodNext == METHOD_FILE && cmdLc == 8'h00)) begin
      swNext = `SW_NO_FILE;
    end else if (tryToolkit) begin
      swNext = {`SW_TOOLKIT_HI, toolkitLen};
    end else begin
      swNext = `SW_OK;
    end
  end

  // next open flag for each logical channel
  // open and close pulses come from the channel management logic
  // the card chooses the number of a new channel, nothing checked here
  generate
    for (genvar ch = 0; ch < `CHAN_COUNT; ch++) begin : gen_chan
      if (ch == 0) begin : gen_basic
        // basic channel pinned open whatever the pulses say
        assign chanOpen_next[ch] = 1'b1;
      end else begin : gen_extra
        // an open pulse wins over a close of the same channel
        assign chanOpen_next[ch] = (openChanValid && openChanNum == 2'(ch)) ||
                                   (chanOpen_reg[ch] && !(closeChanValid && closeChanNum == 2'(ch)));
      end
    end
  endgenerate

  // open channel set register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // only the basic channel open out of reset
      chanOpen_reg <= `CHAN_OPEN_RESET;
    end else begin
      // take the per-channel next flags
      chanOpen_reg <= chanOpen_next;
    end
  end

  // record and tag pointer validity
  // nothing here sets the pointers again; a later command owns that
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // pointers undefined out of reset
      pointersValid <= 1'b0;
    end else if (cmdValid && swNext == `SW_OK) begin
      // a select ending in 9000 drops both pointers; a 91xx toolkit status leaves them as they are
      pointersValid <= 1'b0;
    end
  end

  // result strobe, one cycle after each header
  always_ff @(posedge clk) begin
    if (!resetn) begin
      decValid <= 1'b0;
    end else begin
      // follows the header strobe one cycle late
      decValid <= cmdValid;
    end
  end

  // channel number taken from the class byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channelNum <= 2'd0;
    end else if (cmdValid) begin
      // low two class bits route the command
      channelNum <= chanIn;
    end
  end

  // selection method and data field meaning
  always_ff @(posedge clk) begin
    if (!resetn) begin
      selMethod   <= METHOD_FILE;
      dataMeaning <= DATA_NONE;
    end else if (cmdValid) begin
      // method follows P1, data meaning follows P1 and Lc, held until the next header
      selMethod   <= methodNext;
      dataMeaning <= meaningNext;
    end
  end

  // session control and occurrence, meaningful for application id only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sessionApplies <= 1'b0;
      sessionCtrl    <= 2'b00;
      occurrence     <= OCC_FIRST;
    end else if (cmdValid) begin
      if (cmdP1 == `P1_BY_APP_ID) begin
        // application id: pass session and occurrence bits on
        sessionApplies <= 1'b1;
        sessionCtrl    <= cmdP2[6:5];
        occurrence     <= occurrence_e'(cmdP2[1:0]);
      end else begin
        // other methods: b7 b6 and b2 b1 carry no meaning
        sessionApplies <= 1'b0;
        sessionCtrl    <= 2'b00;
        occurrence     <= OCC_FIRST;
      end
    end
  end

  // response data option
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sendTemplate <= 1'b0;
    end else if (cmdValid) begin
      // template only after a good select that asks for it
      sendTemplate <= (swNext == `SW_OK || swNext[15:8] == `SW_TOOLKIT_HI) &&
                      cmdP2[4:2] == `RESP_TEMPLATE;
    end
  end

  // root directory becomes current on an empty file-id select
  always_ff @(posedge clk) begin
    if (!resetn) begin
      selectRoot <= 1'b0;
    end else if (cmdValid) begin
      // empty data field with the no-data coding
      selectRoot <= isSelect && cmdP1 == `P1_BY_FILE && cmdLc == 8'h00 &&
                    cmdP2 == `P2_NO_DATA;
    end
  end

  // truncated application id matched as a prefix
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prefixMatch <= 1'b0;
    end else if (cmdValid) begin
      // only selection by application id compares prefixes
      prefixMatch <= (cmdP1 == `P1_BY_APP_ID);
    end
  end

  // file-id search running after a miss
  always_ff @(posedge clk) begin
    if (!resetn) begin
      searchRun_reg <= 1'b0;
    end else if (cmdValid) begin
      // start only for a select that found nothing yet
      searchRun_reg <= isSelect && methodNext == METHOD_FILE && swNext == `SW_NO_FILE;
    end else if (searchFound || searchStage == 2'd2) begin
      // stop once found or all three places tried
      searchRun_reg <= 1'b0;
    end
  end

  // search place: children, parent, then parent's children
  always_ff @(posedge clk) begin
    if (!resetn) begin
      searchStage <= 2'd0;
    end else if (cmdValid) begin
      // every header starts at the current directory's children
      searchStage <= 2'd0;
    end else if (searchRun_reg && !searchFound && searchStage != 2'd2) begin
      // one step per cycle while nothing matches
      searchStage <= searchStage + 2'd1;
    end
  end

  // status word, held until the next header
  always_ff @(posedge clk) begin
    if (!resetn) begin
      statusWord <= `SW_OK;
    end else if (cmdValid) begin
      // chosen by the priority chain above
      statusWord <= swNext;
    end
  end

endmodule

// ### card_select_checker.sv
// assertions for the select decoder ports
`timescale 1ns/10ps
module card_select_checker
  import card_select_pkg::*;
(
  // watched ports
  input wire logic        clk, resetn, cmdValid, cardToolkitSupport, decValid, selectRoot, sessionApplies,
  input wire logic        pointersValid,
  input wire logic [7:0]  cmdCla, cmdIns, cmdP1, cmdP2, cmdLc,
  input wire logic [1:0]  channelNum,
  input wire logic [3:0]  chanOpen,
  input wire logic [15:0] statusWord,
  input select_method_e   selMethod,
  input occurrence_e      occurrence
);
  // select header seen
  wire sel = cmdValid && cmdIns == 8'hA4;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pulse_timing_a: assert property (decValid == $past(cmdValid)) else $error("result pulse off");
  chan_route_a: assert property (cmdValid |=> channelNum == $past(cmdCla[1:0])) else $error("channel");
  basic_open_a: assert property (chanOpen[0]) else $error("basic channel closed");
  closed_chan_a: assert property (sel && !chanOpen[cmdCla[1:0]] |=> statusWord == 16'h6881) else $error("closed");
  app_method_a: assert property (sel && cmdP1 == 8'h04 |=> selMethod == METHOD_APP_ID) else $error("method");
  session_only_a: assert property (cmdValid && cmdP1 != 8'h04 |=> !sessionApplies) else $error("session");
  occ_ignore_a: assert property (cmdValid && cmdP1 != 8'h04 |=> occurrence == OCC_FIRST) else $error("occ");
  root_sel_a: assert property (sel && cmdP1 == 8'h00 && cmdLc == 8'h00 && cmdP2 == 8'h0C |=> selectRoot)
    else $error("root");
  unknown_ins_a: assert property (cmdValid && cmdIns != 8'hA4 |=> statusWord == 16'h6D00) else $error("ins");
  bad_param_a: assert property (sel && chanOpen[cmdCla[1:0]] && cmdP1 == 8'h02 |=> statusWord == 16'h6A86)
    else $error("p1p2");
  toolkit_sw_a: assert property (cmdValid && !cardToolkitSupport |=> statusWord[15:8] != 8'h91
    && statusWord != 16'h9300) else $error("toolkit");
  ptr_undef_a: assert property (decValid && statusWord == 16'h9000 |-> !pointersValid) else $error("ptr");
  // main scenarios
  cover property (sel ##1 statusWord == 16'h9000);
  cover property (decValid && selectRoot);
  cover property (decValid && statusWord[15:8] == 8'h91);
endmodule
bind card_channel_file_select_decoder card_select_checker i_card_select_checker (.*);

// ### card_terminal_model.sv
// terminal model that frames command headers
`timescale 1ns/10ps
module card_terminal_model (
  input wire logic       clk, go, bend,
  input wire logic [7:0] cla, ins, p1, p2, lc,
  output logic           cmdValid,
  output logic [7:0]     cmdCla, cmdIns, cmdP1, cmdP2, cmdLc
);
  initial cmdValid = 1'b0;
  // one header per request, fields scrambled outside it
  always @(posedge clk) begin
    cmdValid <= go;
    if (go) begin
      cmdCla <= cla;
      cmdIns <= ins;
      cmdP1 <= p1;
      cmdLc <= lc;
      if (!bend && p1 == 8'h00 && lc == 8'h00) cmdP2 <= 8'h0C;
      else if (!bend && p1 != 8'h04) cmdP2 <= {p2[7:2], 2'b00};
      else cmdP2 <= p2;
    end else
      {cmdCla, cmdIns, cmdP1, cmdP2, cmdLc} <= ~{cmdCla, cmdIns, cmdP1, cmdP2, cmdLc};
  end
endmodule

// ### tb.sv
// self-checking bench for the select decoder
`timescale 1ns/10ps
module tb;
  import card_select_pkg::*;
  logic clk = 0, resetn = 0, go = 0, bend = 0, tk = 0, found = 1, opn = 0, cls = 0, tkp = 0;
  logic [1:0] onum = '0, cnum = '0;
  logic [7:0] cla = '0, ins = '0, p1 = '0, p2 = '0, lc = '0, tkl = '0;
  logic cmdValid, decValid, sessionApplies, sendTemplate, selectRoot, prefixMatch, pointersValid;
  logic [7:0] cmdCla, cmdIns, cmdP1, cmdP2, cmdLc;
  logic [1:0] channelNum, sessionCtrl, searchStage;
  logic [3:0] chanOpen;
  logic [15:0] statusWord;
  select_method_e selMethod;
  data_meaning_e dataMeaning;
  occurrence_e occurrence;
  int errors = 0, total_checks = 0, cyc = 0;
  logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h09};
  data_meaning_e dm [6] = '{DATA_FILE_NUMBER, DATA_FILE_NUMBER, DATA_NONE, DATA_DIR_NAME, DATA_PATH, DATA_PATH};
  card_terminal_model i_card_terminal_model (.clk, .go, .bend, .cla, .ins, .p1, .p2, .lc, .cmdValid, .cmdCla,
    .cmdIns, .cmdP1, .cmdP2, .cmdLc);
  card_channel_file_select_decoder i_card_channel_file_select_decoder (.clk, .resetn, .cmdValid, .cmdCla, .cmdIns,
    .cmdP1, .cmdP2, .cmdLc, .cardToolkitSupport(tk), .searchFound(found), .openChanNum(onum), .openChanValid(opn),
    .closeChanNum(cnum), .closeChanValid(cls), .toolkitPending(tkp), .toolkitLen(tkl), .decValid, .channelNum,
    .selMethod, .dataMeaning, .sessionCtrl, .sessionApplies, .occurrence, .sendTemplate, .selectRoot, .prefixMatch,
    .searchStage, .pointersValid, .chanOpen, .statusWord);
  always #4 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one header through the terminal, result sampled a cycle after it lands
  task automatic send(input logic [7:0] c, i, a, b, l);
    @(posedge clk);
    {go, cla, ins, p1, p2, lc} <= {1'b1, c, i, a, b, l};
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    #1;
    chk(decValid, 1);
  endtask
  // card-side channel open or close pulse
  task automatic chan(input logic o, c, input logic [1:0] n);
    @(posedge clk);
    {opn, cls, onum, cnum} <= {o, c, n, n};
    @(posedge clk);
    {opn, cls} <= 2'b00;
    #1;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    #1;
    chk(chanOpen, 4'h1);
    chk(statusWord, 16'h9000);
    foreach (codes[k]) begin
      send(8'h00, 8'hA4, codes[k], 8'h04, 8'h02);
      chk(selMethod, k);
      chk(dataMeaning, dm[k]);
      chk(statusWord, 16'h9000);
      chk(pointersValid, 0);
      chk(prefixMatch, codes[k] == 8'h04);
    end
    for (int k = 0; k < 4; k++) begin
      send(8'h00, 8'hA4, 8'h04, 8'h44 | 8'(k), 8'h05);
      chk(occurrence, k);
      chk(sessionCtrl, 2);
      chk({prefixMatch, sendTemplate}, 3);
    end
    @(posedge clk) bend <= 1;
    send(8'h00, 8'hA4, 8'h01, 8'h07, 8'h02);
    chk({sessionApplies, occurrence}, 0);
    @(posedge clk) bend <= 0;
    send(8'h00, 8'hA4, 8'h00, 8'h04, 8'h00);
    chk({selectRoot, sendTemplate}, 2);
    send(8'h00, 8'hB0, 8'h00, 8'h04, 8'h02);
    chk(statusWord, 16'h6D00);
    send(8'h00, 8'hA4, 8'h02, 8'h04, 8'h02);
    chk(statusWord, 16'h6A86);
    send(8'h02, 8'hA4, 8'h00, 8'h04, 8'h02);
    chk(statusWord, 16'h6881);
    chan(1, 0, 2);
    chan(0, 1, 0);
    chk(chanOpen, 4'h5);
    send(8'h02, 8'hA4, 8'h00, 8'h04, 8'h02);
    chk({channelNum, statusWord}, 18'h2_9000);
    chan(0, 1, 2);
    chk(chanOpen, 4'h1);
    @(posedge clk) {tkp, tkl} <= 9'h110;
    send(8'h00, 8'hA4, 8'h00, 8'h04, 8'h02);
    chk(statusWord, 16'h9000);
    @(posedge clk) tk <= 1;
    send(8'h00, 8'hA4, 8'h00, 8'h04, 8'h02);
    chk(statusWord, 16'h9110);
    @(posedge clk) {found, tkp} <= 2'b00;
    send(8'h00, 8'hA4, 8'h00, 8'h04, 8'h02);
    chk({searchStage, statusWord}, 18'h0_6A82);
    @(posedge clk);
    #1;
    chk(searchStage, 1);
    repeat (3) @(posedge clk);
    #1;
    chk(searchStage, 2);
    tally_and_finish;
  end
endmodule
